/* design/spf_ctrl.v */
// spf_ctrl.v: self-programming flash controller with page buffer,
// command arming windows, section busy tracking and lock/fuse readback.
// assumes the cpu core on the same clock gives one-cycle store/load strobes
// and a one-cycle register write strobe; the flash array itself is outside.
//
// Overview of operation
// RULE1: store enable arms store for four cycles
// RULE2: plain store fills buffer word at pointer
// RULE3: store enable stays set while programming
// RULE4: only six command patterns arm anything
// RULE5: page write commits buffer to pointer page
// RULE6: page erase clears pointer page
// RULE7: stall cpu when stalling section programmed
// RULE8: concurrent section programming sets busy flag
// RULE9: busy flag clears on reenable or load
// RULE10: reenable refused while programming busy
// RULE11: reenable during buffer load discards data
// RULE12: lock set store programs lock byte
// RULE13: lock set load returns lock or fuse
// RULE14: signature load returns row, store ignored
// RULE15: ready interrupt while store enable clear
// RULE16: boot size pair selects boot start
// RULE17: section split at word 0x1c00
// RULE18: thirteen bit counter, 64 word pages
// RULE19: software keeps pointer bit zero clear
// RULE20: register at 0x57 / 0x37, reset zero
// RULE21: software waits, then writes and stores
// RULE22: programming stays busy 3.7 to 4.5 ms
// RULE23: programmed bits read zero, blank one
// RULE24: window counted from write, reset clears
`timescale 1ns/100ps
`default_nettype none
`include "spf_consts.vh"

module spf_ctrl #(
  parameter [22:0] PROG_CYCLES = `SPF_PROG_CYCLES,
  parameter [7:0] FUSE_LOW = 8'hff,
  parameter [7:0] FUSE_HIGH = 8'hff,
  parameter [7:0] FUSE_EXT = 8'hff,
  parameter [7:0] SIG_BYTE0 = 8'h5a,  // arbitrary signature value
  parameter [7:0] SIG_BYTE1 = 8'h3c,  // arbitrary signature value
  parameter [7:0] SIG_BYTE2 = 8'h96   // arbitrary signature value
) (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire reg_io_space_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire store_in,
  input wire load_in,
  input wire [15:0] pointer_in,
  input wire [15:0] data_word_pair_in,
  input wire global_irq_en_in,
  input wire boot_size_hi_in,
  input wire boot_size_lo_in,
  output reg [7:0] reg_rdata_out,
  output reg [7:0] load_data_out,
  output reg load_hit_out,
  output reg cpu_halt_out,
  output reg ready_irq_out,
  output reg section_locked_out,
  output reg flash_erase_out,
  output reg flash_write_out,
  output reg [6:0] flash_page_out,
  output reg [12:0] boot_start_out,
  output reg [7:0] lock_byte_out
);
  // command states, one-hot
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ARMED = 5'b00010;
  localparam [4:0] ST_PROG = 5'b00100;
  localparam [4:0] ST_LOCKP = 5'b01000;
  localparam [4:0] ST_SIG = 5'b10000;

  reg rst_meta;
  reg rst_sync;
  reg [4:0] state;
  reg [2:0] window;
  reg [7:0] csr;
  reg [15:0] page_buf [0:`SPF_PAGE_WORDS-1];
  reg buf_loading;
  reg prog_conc;
  reg [6:0] prog_page;
  wire prog_done;
  reg timer_start;
  integer i;

  // boot start from the fuse pair
  function [12:0] boot_start;
    input [1:0] sz;
    begin
      case (sz)
        2'b11: boot_start = `SPF_BOOT_START_11;
        2'b10: boot_start = `SPF_BOOT_START_10;
        2'b01: boot_start = `SPF_BOOT_START_01;
        default: boot_start = `SPF_BOOT_START_00;
      endcase
    end
  endfunction

  // RULE20: register hit in either space
  function reg_hit;
    input io;
    input [7:0] a;
    begin
      reg_hit = io ? (a[5:0] == `SPF_CSR_IO_ADDR && a[7:6] == 2'b00) : (a == `SPF_CSR_DATA_ADDR);
    end
  endfunction

  // reset release through two flops so deassertion is clean
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // RULE22: programming time counter
  spf_prog_timer #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_sync),
    .start_in(timer_start),
    .busy_out(),
    .done_out(prog_done)
  );

  wire csr_wr = reg_wr_in && reg_hit(reg_io_space_in, reg_addr_in);
  wire [4:0] wr_low = reg_wdata_in[4:0];
  wire [5:0] wr_six = reg_wdata_in[5:0];
  wire [12:0] word_addr = pointer_in[13:1];
  wire window_open = (window != 3'd0);

  // main sequencer
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      window <= 3'd0;
      csr <= `SPF_CSR_RESET;
      buf_loading <= 1'b0;
      prog_conc <= 1'b0;
      prog_page <= 7'h00;
      timer_start <= 1'b0;
      load_data_out <= 8'h00;
      load_hit_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_page_out <= 7'h00;
      lock_byte_out <= 8'hff;
      for (i = 0; i < `SPF_PAGE_WORDS; i = i + 1) begin
        page_buf[i] <= 16'hffff;
      end
    end else begin
      timer_start <= 1'b0;
      load_hit_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      if (csr_wr) begin
        csr[`SPF_BIT_READY_IRQ_EN] <= reg_wdata_in[`SPF_BIT_READY_IRQ_EN];
      end
      case (state)
        ST_IDLE: begin
          // RULE4: only listed patterns arm; RULE24: window from the write
          if (csr_wr && (wr_low == `SPF_PAT_STORE || wr_low == `SPF_PAT_ERASE || wr_low == `SPF_PAT_WRITE
              || wr_low == `SPF_PAT_LOCK || wr_low == `SPF_PAT_REENABLE || wr_six == `SPF_PAT_SIG)) begin
            csr[5:0] <= reg_wdata_in[5:0];
            window <= `SPF_STORE_WINDOW;
            state <= (wr_six == `SPF_PAT_SIG) ? ST_SIG : ST_ARMED;
            // RULE11: reenable during a load drops the buffered words
            if (wr_low == `SPF_PAT_REENABLE && buf_loading) begin
              buf_loading <= 1'b0;
              for (i = 0; i < `SPF_PAGE_WORDS; i = i + 1) begin
                page_buf[i] <= 16'hffff;
              end
            end
          end
        end
        ST_ARMED: begin
          // RULE1: store accepted only within the window
          window <= window - 3'd1;
          if (store_in) begin
            window <= 3'd0;
            if (csr[`SPF_BIT_PAGE_ERASE] || csr[`SPF_BIT_PAGE_WRITE]) begin
              // RULE5: RULE6: page from pointer upper bits, data ignored
              prog_page <= word_addr[12:`SPF_WORD_BITS];
              timer_start <= 1'b1;
              // RULE17: section decided by page address
              prog_conc <= (word_addr < `SPF_STALL_START);
              // RULE8: concurrent section becomes busy
              if (word_addr < `SPF_STALL_START) begin
                csr[`SPF_BIT_SECTION_BUSY] <= 1'b1;
              end
              state <= ST_PROG;
            end else if (csr[`SPF_BIT_LOCK_SET]) begin
              // RULE12: lock byte from low data register only
              lock_byte_out <= lock_byte_out & (data_word_pair_in[7:0] | 8'hc0);
              timer_start <= 1'b1;
              state <= ST_LOCKP;
            end else if (csr[`SPF_BIT_REENABLE]) begin
              // RULE10: only reached once programming ended
              csr[`SPF_BIT_SECTION_BUSY] <= 1'b0;
              csr[5:0] <= 6'h00;
              state <= ST_IDLE;
            end else begin
              // RULE2: buffer fill, pointer bit zero ignored; RULE18
              page_buf[word_addr[`SPF_WORD_BITS-1:0]] <= data_word_pair_in;
              buf_loading <= 1'b1;
              // RULE9: page load releases the busy flag
              csr[`SPF_BIT_SECTION_BUSY] <= 1'b0;
              csr[5:0] <= 6'h00;
              state <= ST_IDLE;
            end
          end else if (load_in && csr[`SPF_BIT_LOCK_SET] && window > (`SPF_STORE_WINDOW - `SPF_LOAD_WINDOW)) begin
            // RULE13: RULE23: lock or fuse byte by pointer bits
            load_hit_out <= 1'b1;
            case (pointer_in[1:0])
              2'b00: load_data_out <= FUSE_LOW;
              2'b01: load_data_out <= lock_byte_out;
              2'b10: load_data_out <= FUSE_EXT;
              default: load_data_out <= FUSE_HIGH;
            endcase
            csr[5:0] <= 6'h00;
            window <= 3'd0;
            state <= ST_IDLE;
          end else if (window == 3'd1) begin
            // RULE1: timeout clears the command bits
            csr[5:0] <= 6'h00;
            state <= ST_IDLE;
          end
        end
        ST_SIG: begin
          // RULE14: load returns a signature byte, store does nothing
          window <= window - 3'd1;
          if (load_in && window > (`SPF_STORE_WINDOW - `SPF_LOAD_WINDOW)) begin
            load_hit_out <= 1'b1;
            case (pointer_in[2:0])
              3'd0: load_data_out <= SIG_BYTE0;
              3'd2: load_data_out <= SIG_BYTE1;
              3'd4: load_data_out <= SIG_BYTE2;
              default: load_data_out <= 8'hff;
            endcase
            csr[5:0] <= 6'h00;
            window <= 3'd0;
            state <= ST_IDLE;
          end else if (window == 3'd1) begin
            csr[5:0] <= 6'h00;
            state <= ST_IDLE;
          end
        end
        ST_PROG: begin
          // RULE3: store enable held until the timer ends
          if (prog_done) begin
            flash_page_out <= prog_page;
            if (csr[`SPF_BIT_PAGE_WRITE]) begin
              flash_write_out <= 1'b1;
              buf_loading <= 1'b0;
            end else begin
              flash_erase_out <= 1'b1;
            end
            csr[5:0] <= 6'h00;
            state <= ST_IDLE;
          end
        end
        ST_LOCKP: begin
          if (prog_done) begin
            csr[5:0] <= 6'h00;
            state <= ST_IDLE;
          end
        end
        default: begin
          csr[5:0] <= 6'h00;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // registered outputs derived from state and fuses
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata_out <= 8'h00;
      cpu_halt_out <= 1'b0;
      ready_irq_out <= 1'b0;
      section_locked_out <= 1'b0;
      boot_start_out <= `SPF_BOOT_START_00;
    end else begin
      // unmapped reads return zero
      reg_rdata_out <= (reg_rd_in && reg_hit(reg_io_space_in, reg_addr_in)) ? csr : 8'h00;
      // RULE7: stall the cpu while the stalling section is busy
      cpu_halt_out <= (state == ST_PROG) && !prog_conc && !prog_done;
      // RULE15: level request while store enable is clear
      ready_irq_out <= csr[`SPF_BIT_READY_IRQ_EN] && global_irq_en_in && !csr[`SPF_BIT_STORE_EN];
      // RULE8: concurrent section inaccessible while flagged
      section_locked_out <= csr[`SPF_BIT_SECTION_BUSY];
      // RULE16: boot start from the fuse pair
      boot_start_out <= boot_start({boot_size_hi_in, boot_size_lo_in});
    end
  end
endmodule
`default_nettype wire

/* design/spf_consts.vh */
// spf_consts.vh: offsets, field positions, reset values and timing counts
// of the self-programming flash controller. definitions only.
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH

// control/status register, data space and io space offsets
`define SPF_CSR_DATA_ADDR 8'h57
`define SPF_CSR_IO_ADDR 6'h37
`define SPF_CSR_RESET 8'h00

// control/status bit positions
`define SPF_BIT_READY_IRQ_EN 7
`define SPF_BIT_SECTION_BUSY 6
`define SPF_BIT_SIG_READ 5
`define SPF_BIT_REENABLE 4
`define SPF_BIT_LOCK_SET 3
`define SPF_BIT_PAGE_WRITE 2
`define SPF_BIT_PAGE_ERASE 1
`define SPF_BIT_STORE_EN 0

// legal low five bit command patterns, low six bits for signature read
`define SPF_PAT_STORE 5'h01
`define SPF_PAT_ERASE 5'h03
`define SPF_PAT_WRITE 5'h05
`define SPF_PAT_LOCK 5'h09
`define SPF_PAT_REENABLE 5'h11
`define SPF_PAT_SIG 6'h21

// arming windows in core cycles
`define SPF_STORE_WINDOW 3'd4
`define SPF_LOAD_WINDOW 3'd3

// geometry: 13 bit counter, 64 word pages
`define SPF_PC_WIDTH 13
`define SPF_WORD_BITS 6
`define SPF_PAGE_WORDS 64
`define SPF_STALL_START 13'h1c00
`define SPF_CONC_LAST 13'h1bff

// boot section start per boot size fuse pair
`define SPF_BOOT_START_11 13'h1f80
`define SPF_BOOT_START_10 13'h1f00
`define SPF_BOOT_START_01 13'h1e00
`define SPF_BOOT_START_00 13'h1c00

// programming time: 3.7 ms least, 4.5 ms most, at 125 MHz (8 ns)
`define SPF_PROG_MIN_NS 3700000
`define SPF_PROG_MAX_NS 4500000
`define SPF_CLK_NS 8
// least programming time in core cycles, rounded up: 3700000 ns / 8 ns
`define SPF_PROG_CYCLES 23'd462500

`endif

/* design/spf_prog_timer.v */
// spf_prog_timer.v: counts one programming operation down to its end.
// assumes start is a one-cycle pulse on the core clock; reset already synced.
`timescale 1ns/100ps
`default_nettype none
`include "spf_consts.vh"

module spf_prog_timer #(
  parameter [22:0] PROG_CYCLES = `SPF_PROG_CYCLES
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire start_in,
  output reg busy_out,
  output reg done_out
);
  reg [22:0] count;

  // load on start, pulse done when the count runs out
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 23'h000000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count <= PROG_CYCLES - 23'h000001;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (count == 23'h000000) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count - 23'h000001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/spf_ctrl_properties.sv */
// spf_ctrl_properties.sv: port-level timing checks of the flash controller.
// assumes it is bound into spf_ctrl; one core clock, reset active low.
`timescale 1ns/100ps
`default_nettype none
module spf_ctrl_properties #(
  parameter [22:0] PROG_CYCLES = 23'd20
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_rd_in,
  input wire logic load_in,
  input wire logic global_irq_en_in,
  input wire logic boot_size_hi_in,
  input wire logic boot_size_lo_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic load_hit_out,
  input wire logic cpu_halt_out,
  input wire logic ready_irq_out,
  input wire logic section_locked_out,
  input wire logic flash_erase_out,
  input wire logic flash_write_out,
  input wire logic [12:0] boot_start_out,
  input wire logic [7:0] lock_byte_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // outputs lag the released reset by three flops, so live gates the map check
  logic [1:0] live;
  int run;
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      live <= 2'd0;
      run <= 0;
    end else begin
      if (live != 2'd3) live <= live + 2'd1;
      run <= cpu_halt_out ? run + 1 : 0;
    end
  end
  a_boot_start_map: assert property (live == 2'd3 && $stable({boot_size_hi_in, boot_size_lo_in})
    |-> boot_start_out == 13'(14'h2000 - (14'h80 << (2'd3 - {boot_size_hi_in, boot_size_lo_in}))))
    else $error("boot start does not match size pair");
  a_irq_needs_gie: assert property (ready_irq_out |-> $past(global_irq_en_in))
    else $error("ready request without global enable");
  a_halt_no_irq: assert property (cpu_halt_out |-> !ready_irq_out)
    else $error("ready request while stalled");
  a_load_answer: assert property (load_hit_out |-> $past(load_in))
    else $error("load answer without load");
  a_rdata_cause: assert property (reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
    else $error("read data without read");
  a_done_pulse: assert property (flash_erase_out || flash_write_out |=> !(flash_erase_out || flash_write_out))
    else $error("completion pulse too long");
  a_lock_top_ones: assert property (lock_byte_out[7:6] == 2'b11)
    else $error("unused lock bits not one");
  a_halt_length: assert property ($fell(cpu_halt_out) |-> run >= PROG_CYCLES - 23'd3)
    else $error("stall shorter than programming time");
  a_locked_hold: assert property ($rose(section_locked_out) |-> section_locked_out [*8])
    else $error("section busy flag dropped early");
endmodule
bind spf_ctrl spf_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) spf_ctrl_properties_inst (.*);
`default_nettype wire

/* testbench/spf_cpu_model.sv */
// spf_cpu_model.sv: core model issuing register cycles and store/load strobes.
// assumes the controller samples on the rising edge of the shared clock.
`timescale 1ns/100ps
`default_nettype none
module spf_cpu_model (
  input wire logic ref_clk_in,
  output var logic reg_wr_in,
  output var logic reg_rd_in,
  output var logic reg_io_space_in,
  output var logic [7:0] reg_addr_in,
  output var logic [7:0] reg_wdata_in,
  output var logic store_in,
  output var logic load_in,
  output var logic [15:0] pointer_in,
  output var logic [15:0] data_word_pair_in
);
  initial begin
    {reg_wr_in, reg_rd_in, reg_io_space_in, store_in, load_in} = 5'h00;
    {reg_addr_in, reg_wdata_in, pointer_in, data_word_pair_in} = 48'h0;
  end
  // register write, then the instruction right after
  task automatic cmd(input logic [7:0] v, input logic [15:0] p, d, input logic [1:0] op);
    @(negedge ref_clk_in);
    {reg_wr_in, reg_io_space_in, reg_addr_in, reg_wdata_in} = {2'b10, 8'h57, v};
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
    {load_in, store_in} = op;
    // byte bit kept clear on a store
    pointer_in = op[0] ? {p[15:1], 1'b0} : p;
    data_word_pair_in = d;
    @(negedge ref_clk_in);
    {load_in, store_in} = 2'b00;
    // released lines carry garbage so stale values cannot pass
    {pointer_in, data_word_pair_in, reg_wdata_in} = ~{pointer_in, data_word_pair_in, reg_wdata_in};
  endtask
  task automatic rd(input logic io, input logic [7:0] a);
    @(negedge ref_clk_in);
    {reg_rd_in, reg_io_space_in, reg_addr_in} = {1'b1, io, a};
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// tb.sv: self-checking bench of the self-programming flash controller.
// assumes spf_ctrl, spf_cpu_model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic global_irq_en_in = 1'b0;
  logic boot_size_hi_in = 1'b1;
  logic boot_size_lo_in = 1'b1;
  logic reg_wr_in, reg_rd_in, reg_io_space_in, store_in, load_in, load_hit_out, cpu_halt_out;
  logic ready_irq_out, section_locked_out, flash_erase_out, flash_write_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, load_data_out, lock_byte_out, d8;
  logic [15:0] pointer_in, data_word_pair_in, nw = 16'h0, ne = 16'h0;
  logic [6:0] flash_page_out;
  logic [12:0] boot_start_out;
  logic [15:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [7:0] fz[4] = '{8'h62, 8'hff, 8'hfd, 8'h99};
  logic [7:0] sg[4] = '{8'h5a, 8'h3c, 8'h96, 8'hff};
  int mismatches = 0;
  int checks = 0;
  spf_ctrl #(.PROG_CYCLES(23'd20), .FUSE_LOW(8'h62), .FUSE_HIGH(8'h99), .FUSE_EXT(8'hfd),
    .SIG_BYTE0(8'h5a), .SIG_BYTE1(8'h3c), .SIG_BYTE2(8'h96)) spf_ctrl_inst (.*);
  spf_cpu_model spf_cpu_model_inst (.*);
  always #4 ref_clk_in = ~ref_clk_in;
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic take(input string n, input logic [7:0] s);
    check(n, {8'h0, s}, exp_q.size() == 0 ? 16'hxxxx : exp_q.pop_front());
  endtask
  // answers are matched to the oldest note; completion pulses are counted
  always @(posedge ref_clk_in) begin
    if (rd_d) take("rdata", reg_rdata_out);
    if (load_hit_out) take("load_data", load_data_out);
    if (flash_write_out) nw <= nw + 16'h1;
    if (flash_erase_out) ne <= ne + 16'h1;
    rd_d <= reg_rd_in;
  end
  task automatic rdx(input logic io, input logic [7:0] a, e);
    exp_q.push_back({8'h0, e});
    spf_cpu_model_inst.rd(io, a);
  endtask
  task automatic cm(input logic [7:0] v, input logic [15:0] p, input logic [1:0] op);
    spf_cpu_model_inst.cmd(v, p, {8'($urandom), d8}, op);
  endtask
  task automatic ldx(input logic [7:0] v, input logic [15:0] p, input logic [7:0] e);
    exp_q.push_back({8'h0, e});
    cm(v, p, 2'b10);
    repeat (3) @(negedge ref_clk_in);
  endtask
  // ready request is the idle sign; bounded so a hang ends the run
  task automatic wait_idle;
    int i;
    repeat (3) @(negedge ref_clk_in);
    for (i = 0; i < 200 && ready_irq_out !== 1'b1; i++) @(negedge ref_clk_in);
    if (ready_irq_out !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask
  initial begin
    int i;
    void'($urandom(32'h0fc2f1b9));
    d8 = 8'h00;
    repeat (20) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check("lock_byte", {8'h0, lock_byte_out}, 16'h00ff);
    rdx(1'b0, 8'h57, 8'h00);
    rdx(1'b1, 8'h37, 8'h00);
    rdx(1'b0, 8'h58, 8'h00);
    cm(8'h01, 16'h0, 2'b00);
    repeat (5) @(negedge ref_clk_in);
    rdx(1'b0, 8'h57, 8'h00);
    for (i = 0; i < 6; i++) begin
      cm(i == 0 ? 8'h07 : 8'($urandom) & 8'h3e, 16'h0, 2'b00);
      rdx(1'b0, 8'h57, 8'h00);
    end
    cm(8'h80, 16'h0, 2'b00);
    repeat (3) @(negedge ref_clk_in);
    check("irq", {15'h0, ready_irq_out}, 16'h0000);
    global_irq_en_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check("irq", {15'h0, ready_irq_out}, 16'h0001);
    // io space reaches the register, the same offset in data space does not
    rdx(1'b1, 8'h37, 8'h80);
    rdx(1'b0, 8'h37, 8'h00);
    // fill, then page write in the concurrent section with a refused reenable
    cm(8'h81, 16'h018b, 2'b01);
    rdx(1'b0, 8'h57, 8'h80);
    cm(8'h85, 16'h0180, 2'b01);
    rdx(1'b0, 8'h57, 8'hc5);
    check("locked", {15'h0, section_locked_out}, 16'h0001);
    cm(8'h91, 16'h0, 2'b01);
    rdx(1'b0, 8'h57, 8'hc5);
    wait_idle();
    check("writes", nw, 16'h0001);
    check("page", {9'h0, flash_page_out}, 16'h0003);
    rdx(1'b0, 8'h57, 8'hc0);
    cm(8'h91, 16'h0, 2'b01);
    rdx(1'b0, 8'h57, 8'h80);
    // erase in the stalling section halts the core
    cm(8'h83, 16'h3800, 2'b01);
    repeat (2) @(negedge ref_clk_in);
    check("halt", {15'h0, cpu_halt_out}, 16'h0001);
    check("locked", {15'h0, section_locked_out}, 16'h0000);
    wait_idle();
    check("erases", ne, 16'h0001);
    check("page", {9'h0, flash_page_out}, 16'h0070);
    for (i = 0; i < 4; i++) ldx(8'h89, i[15:0], fz[i]);
    d8 = 8'($urandom);
    cm(8'h89, 16'h0, 2'b01);
    wait_idle();
    check("lock_byte", {8'h0, lock_byte_out}, {8'h0, d8 | 8'hc0});
    ldx(8'h89, 16'h0001, d8 | 8'hc0);
    for (i = 0; i < 4; i++) ldx(8'ha1, 16'(2 * i), sg[i]);
    cm(8'ha1, 16'h0180, 2'b01);
    repeat (6) @(negedge ref_clk_in);
    check("pulses", nw + ne, 16'h0002);
    // reset inside an open window drops the command and the whole register
    cm(8'h81, 16'h0, 2'b00);
    rst_b_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check("irq", {15'h0, ready_irq_out}, 16'h0000);
    rdx(1'b0, 8'h57, 8'h00);
    for (i = 0; i < 4; i++) begin
      {boot_size_hi_in, boot_size_lo_in} = i[1:0];
      repeat (3) @(negedge ref_clk_in);
      check("boot_start", {3'h0, boot_start_out}, 16'h2000 - (16'h0080 << (3 - i)));
    end
    repeat (5) @(negedge ref_clk_in);
    check("pending", 16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
